// *** dv/pvt_modes_checker.sv ***
// Assertion checker for the profile velocity / profile torque mode block
`include "pvt_defs.vh"
`default_nettype none
module pvt_modes_checker #(
   parameter TICK_CYCLES = 10
) (
   // Clock, reset, enable
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Drive side
   input wire logic        op_enabled,
   input wire logic [31:0] vel_actual,
   input wire logic [31:0] vel_setpoint,
   input wire logic [31:0] trq_setpoint,
   input wire logic [31:0] speed_limit,
   input wire logic        true_torque,
   input wire logic        field_weak_en,
   input wire logic [1:0]  mode_active
);
   // ========
   // Shadow state
   logic [31:0] max_trq_r;
   logic [31:0] step_r;
   logic [31:0] trq_prev_r;
   wire signed [32:0] trq_delta = $signed({trq_setpoint[31], trq_setpoint})
                                - $signed({trq_prev_r[31], trq_prev_r});
   // Software copies of cap and per-tick step; a lowered cap is never written mid-run
   always_ff @(posedge clk) begin
      trq_prev_r <= trq_setpoint;
      if (rst) begin
         max_trq_r <= `PVT_RST_MAXTRQ;
         step_r    <= 32'h0000_0001;
      end else if (ce && reg_wr && reg_addr == `PVT_A_MAX_TRQ) begin
         max_trq_r <= reg_wdata;
      end else if (ce && reg_wr && reg_addr == `PVT_A_TRQ_SLOPE) begin
         step_r <= (reg_wdata < 32'h0000_07D0) ? 32'h0000_0001 : reg_wdata / 32'h0000_03E8;
      end
   end
   // ========
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_RDATA_IDLE: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not cleared");
   AST_MODE_PV: assert property (ce && op_enabled && reg_wr && reg_addr == `PVT_A_MODE
      && reg_wdata[7:0] == `PVT_MODE_PV |=> ##[0:2] mode_active == 2'b01)
      else $error("velocity mode not entered");
   AST_MODE_PT: assert property (ce && op_enabled && reg_wr && reg_addr == `PVT_A_MODE
      && reg_wdata[7:0] == `PVT_MODE_PT |=> ##[0:2] mode_active == 2'b10)
      else $error("torque mode not entered");
   AST_SUBMODE_TRUE: assert property (ce && reg_wr && reg_addr == `PVT_A_SUBMODE
      && reg_wdata[5] |=> ##[0:2] true_torque)
      else $error("true torque not selected");
   AST_NO_LIMIT: assert property (true_torque [*2] |-> speed_limit == 32'h7FFF_FFFF)
      else $error("speed limited in true torque");
   AST_NO_FIELD_WEAK: assert property (field_weak_en |-> !true_torque)
      else $error("field weakening in true torque");
   AST_FIELD_WEAK: assert property (mode_active[1] && !true_torque |-> field_weak_en)
      else $error("field weakening off in limited velocity control");
   AST_VEL_DEM_RD: assert property (ce && reg_rd && reg_addr == `PVT_A_VEL_DEM
      |=> reg_rdata == vel_setpoint)
      else $error("velocity demand differs from setpoint");
   AST_VEL_ACT_RD: assert property (ce && reg_rd && reg_addr == `PVT_A_VEL_ACT
      |=> reg_rdata == $past(vel_actual))
      else $error("actual speed misread");
   AST_TRQ_CAP: assert property (mode_active[1] |->
      $signed(trq_setpoint) <= $signed(max_trq_r) && $signed(trq_setpoint) >= -$signed(max_trq_r))
      else $error("torque above maximum");
   AST_TRQ_SLOPE: assert property (mode_active[1] && $past(mode_active[1], 2) && op_enabled
      && $past(op_enabled, 2) |-> trq_delta <= $signed({1'b0, step_r})
      && trq_delta >= -$signed({1'b0, step_r}))
      else $error("torque step above slope");
   // Main scenarios reached
   cover property (mode_active == 2'b01);
   cover property (mode_active == 2'b10 && trq_setpoint != 32'h0);
   cover property (true_torque);
endmodule
bind pvt_modes pvt_modes_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .rst(rst),
   .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .op_enabled(op_enabled), .vel_actual(vel_actual),
   .vel_setpoint(vel_setpoint), .trq_setpoint(trq_setpoint), .speed_limit(speed_limit),
   .true_torque(true_torque), .field_weak_en(field_weak_en), .mode_active(mode_active));
`default_nettype wire

// *** dv/pvt_modes_tb.sv ***
// Self-checking bench for the profile velocity / profile torque mode block
`include "pvt_defs.vh"
`default_nettype none
module pvt_modes_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [31:0] e; logic [31:0] m; bit le; logic [7:0] a;} pvt_exp_t;
   logic        clk, rst, ce, reg_wr, reg_rd, op_enabled, slow, rd_seen;
   logic        true_torque, field_weak_en;
   logic [1:0]  mode_active;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, vel_actual, trq_actual, vel_setpoint, trq_setpoint;
   logic [31:0] speed_limit, v;
   logic [7:0]  rw[4] = '{`PVT_A_ACC, `PVT_A_DEC, `PVT_A_JERK, `PVT_A_VEL_WIN};
   int          miscompares, n_tests, cyc;
   pvt_exp_t    q[$];
   pvt_exp_t    cur;
   // ========
   // Design and plant; short tick keeps ramps brief
   pvt_modes #(.TICK_CYCLES(10)) DUT (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .op_enabled(op_enabled), .vel_actual(vel_actual), .trq_actual(trq_actual),
      .vel_setpoint(vel_setpoint), .trq_setpoint(trq_setpoint), .speed_limit(speed_limit),
      .true_torque(true_torque), .field_weak_en(field_weak_en), .mode_active(mode_active));
   pvt_motor_model u_motor (.clk(clk), .rst(rst), .slow(slow), .vel_setpoint(vel_setpoint),
      .trq_setpoint(trq_setpoint), .vel_actual(vel_actual), .trq_actual(trq_actual));
   // ========
   // Bus tasks; wr, rd and idle each drive both strobes so no signal is driven twice per step
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      n_tests++;
      if (seen !== ex) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input bit le);
      q.push_back('{e, m, le, a});
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_seen) begin
         cur = q.pop_front();
         if (cur.le) begin
            chk($sformatf("reg %h le", cur.a), {31'h0, $signed(reg_rdata) <= $signed(cur.e)},
                32'h1);
         end else begin
            chk($sformatf("reg %h", cur.a), reg_rdata & cur.m, cur.e & cur.m);
         end
      end
      rd_seen <= reg_rd;
   end
   // Hang guard; whole run needs about 1650 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ========
   // Main sequence
   initial begin
      {rst, ce, reg_wr, reg_rd, op_enabled, slow} = 6'b110000;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      void'($urandom(32'h871E7653));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`PVT_A_CTRL, `PVT_RST_CTRL, '1, 0);
      rd(`PVT_A_MAX_VEL, `PVT_RST_MAXVEL, '1, 0);
      rd(`PVT_A_PEAK_TRQ, `PVT_RST_PEAK, '1, 0);
      rd(8'h40, 32'h0, '1, 0);
      wr(`PVT_A_VEL_DEM, 32'h1234_5678);
      rd(`PVT_A_VEL_DEM, 32'h0, '1, 0);
      foreach (rw[i]) begin
         v = $urandom();
         wr(rw[i], v);
         rd(rw[i], v, '1, 0);
      end
      // Trapezoid velocity ramp, then speed window held
      op_enabled <= 1'b1;
      wr(`PVT_A_ACC, 32'h000F_4240);
      wr(`PVT_A_QS_DEC, 32'h000F_4240);
      wr(`PVT_A_DEC, 32'h000F_4240);
      wr(`PVT_A_VEL_WIN, 32'h0000_000A);
      wr(`PVT_A_VEL_WTIME, 32'h0000_0003);
      wr(`PVT_A_TGT_VEL, 32'h0000_1388);
      wr(`PVT_A_MODE, `PVT_MODE_PV);
      idle(15);
      rd(`PVT_A_STAT, 32'h0, 32'h400, 0);
      idle(150);
      rd(`PVT_A_VEL_DEM, 32'h0000_1388, '1, 0);
      rd(`PVT_A_STAT, 32'h400, 32'hC00, 0);
      wr(`PVT_A_POLARITY, 32'h0000_0040);
      idle(200);
      rd(`PVT_A_VEL_DEM, 32'hFFFF_EC78, '1, 0);
      // Halt brakes; status low while braking, high at rest
      wr(`PVT_A_CTRL, 32'h0000_0104);
      idle(12);
      rd(`PVT_A_STAT, 32'h0, 32'h400, 0);
      idle(150);
      rd(`PVT_A_VEL_DEM, 32'h0, '1, 0);
      rd(`PVT_A_STAT, 32'h400, 32'h400, 0);
      // Release on jerk profile climbs far slower than the trapezoid
      wr(`PVT_A_POLARITY, 32'h0);
      wr(`PVT_A_JERK, 32'h0000_03E8);
      wr(`PVT_A_PROF_TYPE, {24'h0, `PVT_PROF_JERK});
      wr(`PVT_A_CTRL, `PVT_RST_CTRL);
      idle(200);
      rd(`PVT_A_VEL_DEM, 32'h0000_012C, '1, 1);
      wr(`PVT_A_PROF_TYPE, {24'h0, `PVT_PROF_TRAP});
      idle(100);
      rd(`PVT_A_VEL_DEM, 32'h0000_1388, '1, 0);
      // Quick stop uses its own steep slope, not the shallow one
      wr(`PVT_A_DEC, 32'h0000_03E8);
      wr(`PVT_A_CTRL, 32'h0);
      idle(100);
      rd(`PVT_A_VEL_DEM, 32'h0, '1, 0);
      // Torque mode on a lagging plant
      // closed loop is taken as up while op_enabled is high
      slow <= 1'b1;
      wr(`PVT_A_CTRL, `PVT_RST_CTRL);
      wr(`PVT_A_MAX_TRQ, 32'h0000_01F4);
      wr(`PVT_A_TRQ_SLOPE, 32'h0001_86A0);
      wr(`PVT_A_TRQ_WIN, 32'h0000_0005);
      wr(`PVT_A_TRQ_WTIME, 32'h0000_0002);
      wr(`PVT_A_TGT_TRQ, 32'h0000_012C);
      wr(`PVT_A_SUBMODE, 32'h0000_0020);
      wr(`PVT_A_MODE, `PVT_MODE_PT);
      idle(15);
      rd(`PVT_A_STAT, 32'h0, 32'h400, 0);
      idle(150);
      rd(`PVT_A_TRQ_DEM, 32'h0000_012C, '1, 0);
      rd(`PVT_A_STAT, 32'h400, 32'hC00, 0);
      wr(`PVT_A_TGT_TRQ, 32'h0000_0320);
      idle(150);
      rd(`PVT_A_TRQ_DEM, 32'h0000_01F4, '1, 0);
      rd(`PVT_A_STAT, 32'h800, 32'h800, 0);
      wr(`PVT_A_CTRL, 32'h0000_0104);
      idle(150);
      rd(`PVT_A_TRQ_DEM, 32'h0, '1, 0);
      rd(`PVT_A_STAT, 32'h400, 32'h400, 0);
      // Peak current lifts then bounds the ceiling
      wr(`PVT_A_MAX_TRQ, 32'h0000_07D0);
      wr(`PVT_A_PEAK_TRQ, 32'h0000_05DC);
      wr(`PVT_A_PEAK_EN, 32'h0000_0001);
      // Back to torque-limited velocity control, field weakening allowed
      wr(`PVT_A_SUBMODE, 32'h0);
      wr(`PVT_A_TRQ_SLOPE, 32'h000F_4240);
      wr(`PVT_A_TGT_TRQ, 32'h0000_0708);
      wr(`PVT_A_CTRL, `PVT_RST_CTRL);
      idle(100);
      rd(`PVT_A_TRQ_DEM, 32'h0000_05DC, '1, 0);
      wr(`PVT_A_PEAK_EN, 32'h0);
      idle(50);
      rd(`PVT_A_TRQ_DEM, `PVT_RATED_TRQ, '1, 0);
      op_enabled <= 1'b0;
      idle(20);
      rd(`PVT_A_TRQ_DEM, 32'h0, '1, 0);
      idle(5);
      end_sim();
   end
endmodule
`default_nettype wire

// *** dv/pvt_motor_model.sv ***
// Behavioural motor stage with speed and current loops
`default_nettype none
module pvt_motor_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Plant speed select, setpoints in, feedback out
   input  wire logic        slow,
   input  wire logic [31:0] vel_setpoint,
   input  wire logic [31:0] trq_setpoint,
   output var  logic [31:0] vel_actual,
   output var  logic [31:0] trq_actual
);
   timeunit 1ns;
   timeprecision 1ps;
   // Slow plant closes a quarter of the gap; leaves a small residue inside any sane window
   always @(posedge clk) begin
      if (rst) begin
         vel_actual <= 32'h0;
         trq_actual <= 32'h0;
      end else if (slow) begin
         vel_actual <= vel_actual + $unsigned($signed(vel_setpoint - vel_actual) >>> 2);
         trq_actual <= trq_actual + $unsigned($signed(trq_setpoint - trq_actual) >>> 2);
      end else begin
         vel_actual <= vel_setpoint;
         trq_actual <= trq_setpoint;
      end
   end
endmodule
`default_nettype wire

// *** pkg/pvt_defs.vh ***
// Constants for the profile velocity / profile torque mode block
`ifndef PVT_DEFS_VH
`define PVT_DEFS_VH
// ================================================================
// Register word offsets (address port is a word index)
`define PVT_A_MODE      8'h00
`define PVT_A_CTRL      8'h01
`define PVT_A_STAT      8'h02
`define PVT_A_TGT_VEL   8'h03
`define PVT_A_VEL_DEM   8'h04
`define PVT_A_VEL_ACT   8'h05
`define PVT_A_VEL_WIN   8'h06
`define PVT_A_VEL_WTIME 8'h07
`define PVT_A_POLARITY  8'h08
`define PVT_A_ACC       8'h09
`define PVT_A_DEC       8'h0A
`define PVT_A_QS_DEC    8'h0B
`define PVT_A_PROF_TYPE 8'h0C
`define PVT_A_JERK      8'h0D
`define PVT_A_MAX_VEL   8'h0E
`define PVT_A_TGT_TRQ   8'h0F
`define PVT_A_MAX_TRQ   8'h10
`define PVT_A_TRQ_DEM   8'h11
`define PVT_A_TRQ_SLOPE 8'h12
`define PVT_A_TRQ_ACT   8'h13
`define PVT_A_TRQ_WIN   8'h14
`define PVT_A_TRQ_WTIME 8'h15
`define PVT_A_PEAK_TRQ  8'h16
`define PVT_A_PEAK_EN   8'h17
`define PVT_A_SUBMODE   8'h18
// ================================================================
// Mode values, bit positions, profile types
`define PVT_MODE_PV     8'h03
`define PVT_MODE_PT     8'h04
`define PVT_CTRL_QSTOP  2
`define PVT_CTRL_HALT   8
`define PVT_STAT_TREACH 10
`define PVT_STAT_LIMIT  11
`define PVT_POL_VEL     6
`define PVT_SUB_TRQ     5
`define PVT_PROF_TRAP   8'h00
`define PVT_PROF_JERK   8'h03
// ================================================================
// Reset values and scaling
`define PVT_RST_CTRL    32'h0000_0004
`define PVT_RST_MAXVEL  32'h7FFF_FFFF
`define PVT_RST_MAXTRQ  32'h0000_03E8
`define PVT_RST_PEAK    32'h0000_03E8
`define PVT_RATED_TRQ   32'h0000_03E8
`define PVT_TICKS_PER_S 32'h0000_03E8
// ================================================================
// Timing: one ramp tick per millisecond at the 25 MHz clock
`define PVT_TICK_US     1000
`define PVT_CLK_MHZ     25
`endif

// *** src/pvt_modes.v ***
// Profile velocity and profile torque mode logic with register port
`include "pvt_defs.vh"
`default_nettype none
// How it works
// - Mode 3 selects profile velocity operation
// - Velocity halt stops; release ramps to target
// - Velocity status bit 10 with halt encodes state
// - Velocity reached after window held window time
// - Polarity bit 6 negates target speed
// - Profile type 0 trapezoid, 3 jerk limited
// - Separate accel, decel, quick-stop slopes
// - Velocity demand readable and drives speed setpoint
// - Enabled profile velocity ramps to target within limits
// - Actual speed readable
// - Mode 4 selects profile torque operation
// - Torque halt stops; release starts per presets
// - Torque reached after window held window time
// - Torque status bit 10 with halt encodes state
// - Bit 11 set when target exceeds max torque
// - Torque values in per-mille of rated current
// - Torque ramp never exceeds max torque
// - Torque ramp rate limited by slope per second
// - Torque demand readable and drives controller
// - Above rated only with peak set; peak clamps all
// - Submode bit 5 picks limited velocity or true torque
module pvt_modes #(
   parameter TICK_CYCLES = `PVT_TICK_US * `PVT_CLK_MHZ
) (
   // Clock, reset, enable
   input  wire        clk,
   input  wire        rst,
   input  wire        ce,
   // Register port
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // Drive state and feedback
   input  wire        op_enabled,
   input  wire [31:0] vel_actual,
   input  wire [31:0] trq_actual,
   // Setpoints to the controller
   output reg  [31:0] vel_setpoint,
   output reg  [31:0] trq_setpoint,
   output reg  [31:0] speed_limit,
   output reg         true_torque,
   output reg         field_weak_en,
   output reg  [1:0]  mode_active
);

   // ================================================================
   // Helpers
   function signed [31:0] f_abs;
      input signed [31:0] v;
      begin
         f_abs = (v < 0) ? -v : v;
      end
   endfunction

   // Clamp to +/- lim (lim non-negative)
   function signed [31:0] f_clamp;
      input signed [31:0] v;
      input signed [31:0] lim;
      begin
         if (v > lim)
            f_clamp = lim;
         else if (v < -lim)
            f_clamp = -lim;
         else
            f_clamp = v;
      end
   endfunction

   // Move cur toward tgt by at most d
   function signed [31:0] f_step;
      input signed [31:0] cur;
      input signed [31:0] tgt;
      input signed [31:0] d;
      begin
         if (tgt > cur)
            f_step = (tgt - cur > d) ? cur + d : tgt;
         else
            f_step = (cur - tgt > d) ? cur - d : tgt;
      end
   endfunction

   // Per-second rate to per-tick, never below one when set
   function signed [31:0] f_per_tick;
      input [31:0] r;
      begin
         if (r == 32'h0)
            f_per_tick = 32'h0;
         else if (r < `PVT_TICKS_PER_S)
            f_per_tick = 32'h1;
         else
            f_per_tick = r / `PVT_TICKS_PER_S;
      end
   endfunction

   // ================================================================
   // Software registers
   reg [7:0]  mode_r;
   reg [31:0] ctrl_r, tgt_vel_r, vel_win_r, vel_wtime_r, pol_r;
   reg [31:0] acc_r, dec_r, qs_dec_r, prof_r, jerk_r, max_vel_r;
   reg [31:0] tgt_trq_r, max_trq_r, trq_slope_r, trq_win_r, trq_wtime_r;
   reg [31:0] peak_trq_r, sub_r;
   reg        peak_en_r;
   // Block state
   reg signed [31:0] vel_dem_r, trq_dem_r, acc_now_r;
   reg [31:0] tick_cnt_r, win_cnt_r;
   reg        tick_r, reached_r, limit_r, halt_d_r;
   reg [1:0]  cond_sel_d_r;

   wire halt  = ctrl_r[`PVT_CTRL_HALT];
   wire qstop = ~ctrl_r[`PVT_CTRL_QSTOP];
   wire pv_on = op_enabled & (mode_r == `PVT_MODE_PV);
   wire pt_on = op_enabled & (mode_r == `PVT_MODE_PT);

   // ================================================================
   // Velocity target path
   reg signed [31:0] vel_pol, vel_ref, vel_lim, vel_rate, vel_step, acc_nxt;
   reg               vel_decel, vel_clip;
   always @* begin
      vel_pol  = pol_r[`PVT_POL_VEL] ? -$signed(tgt_vel_r) : $signed(tgt_vel_r);
      vel_lim  = f_clamp(vel_pol, $signed(max_vel_r));
      vel_clip = (vel_lim != vel_pol);
      // halt or quick stop drives the target to standstill
      vel_ref  = (halt | qstop) ? 32'sh0 : vel_lim;
      // Braking when magnitude shrinks or sign reverses
      vel_decel = (f_abs(vel_ref) < f_abs(vel_dem_r)) ||
                  (vel_ref[31] != vel_dem_r[31] && vel_dem_r != 32'sh0);
      if (qstop)
         vel_rate = f_per_tick(qs_dec_r);
      else if (vel_decel)
         vel_rate = f_per_tick(dec_r);
      else
         vel_rate = f_per_tick(acc_r);
      // jerk limit builds acceleration up gradually
      acc_nxt = acc_now_r + f_per_tick(jerk_r);
      if (acc_nxt > vel_rate)
         acc_nxt = vel_rate;
      if (prof_r[7:0] == `PVT_PROF_JERK)
         vel_step = acc_nxt;
      else
         vel_step = vel_rate;
   end

   // ================================================================
   // Torque target path
   reg signed [31:0] trq_cap, trq_ref;
   always @* begin
      // peak clamps all; above rated only with peak set
      trq_cap = peak_en_r ? $signed(peak_trq_r) : $signed(`PVT_RATED_TRQ);
      // max torque caps every ramp phase
      if ($signed(max_trq_r) < trq_cap)
         trq_cap = $signed(max_trq_r);
      // halt ramps torque back to zero
      trq_ref = halt ? 32'sh0 : f_clamp($signed(tgt_trq_r), trq_cap);
   end

   // ================================================================
   // Target-reached window condition, chosen by mode and halt
   reg        in_win;
   reg [31:0] win_time;
   reg [1:0]  cond_sel;
   always @* begin
      if (halt) begin
         // halted and speed near zero means standstill
         in_win   = f_abs($signed(vel_actual)) <= $signed(vel_win_r);
         win_time = vel_wtime_r;
         cond_sel = 2'h0;
      end else if (pt_on) begin
         in_win   = f_abs($signed(trq_actual) - $signed(tgt_trq_r)) <=
                    $signed(trq_win_r);
         win_time = trq_wtime_r;
         cond_sel = 2'h1;
      end else begin
         // actual speed within window of demanded speed
         in_win   = (f_abs($signed(vel_actual) - vel_dem_r) <= $signed(vel_win_r))
                    && (vel_dem_r == vel_ref);
         win_time = vel_wtime_r;
         cond_sel = 2'h2;
      end
   end

   // ================================================================
   // Register writes
   always @(posedge clk) begin
      if (rst) begin
         mode_r      <= 8'h00;
         ctrl_r      <= `PVT_RST_CTRL;
         tgt_vel_r   <= 32'h0;
         vel_win_r   <= 32'h0;
         vel_wtime_r <= 32'h0;
         pol_r       <= 32'h0;
         acc_r       <= 32'h0;
         dec_r       <= 32'h0;
         qs_dec_r    <= 32'h0;
         prof_r      <= 32'h0;
         jerk_r      <= 32'h0;
         max_vel_r   <= `PVT_RST_MAXVEL;
         tgt_trq_r   <= 32'h0;
         max_trq_r   <= `PVT_RST_MAXTRQ;
         trq_slope_r <= 32'h0;
         trq_win_r   <= 32'h0;
         trq_wtime_r <= 32'h0;
         peak_trq_r  <= `PVT_RST_PEAK;
         peak_en_r   <= 1'b0;
         sub_r       <= 32'h0;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            `PVT_A_MODE:      mode_r      <= reg_wdata[7:0];
            `PVT_A_CTRL:      ctrl_r      <= reg_wdata;
            `PVT_A_TGT_VEL:   tgt_vel_r   <= reg_wdata;
            `PVT_A_VEL_WIN:   vel_win_r   <= reg_wdata;
            `PVT_A_VEL_WTIME: vel_wtime_r <= reg_wdata;
            `PVT_A_POLARITY:  pol_r       <= reg_wdata;
            `PVT_A_ACC:       acc_r       <= reg_wdata;
            `PVT_A_DEC:       dec_r       <= reg_wdata;
            `PVT_A_QS_DEC:    qs_dec_r    <= reg_wdata;
            `PVT_A_PROF_TYPE: prof_r      <= reg_wdata;
            `PVT_A_JERK:      jerk_r      <= reg_wdata;
            `PVT_A_MAX_VEL:   max_vel_r   <= reg_wdata;
            `PVT_A_TGT_TRQ:   tgt_trq_r   <= reg_wdata;
            `PVT_A_MAX_TRQ:   max_trq_r   <= reg_wdata;
            `PVT_A_TRQ_SLOPE: trq_slope_r <= reg_wdata;
            `PVT_A_TRQ_WIN:   trq_win_r   <= reg_wdata;
            `PVT_A_TRQ_WTIME: trq_wtime_r <= reg_wdata;
            `PVT_A_PEAK_TRQ:  peak_trq_r  <= reg_wdata;
            `PVT_A_PEAK_EN:   peak_en_r   <= reg_wdata[0];
            `PVT_A_SUBMODE:   sub_r       <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ================================================================
   // Millisecond tick; counts are parameterised for short simulations
   always @(posedge clk) begin
      if (rst) begin
         tick_cnt_r <= 32'h0;
         tick_r     <= 1'b0;
      end else if (ce) begin
         tick_r <= (tick_cnt_r == TICK_CYCLES - 1);
         if (tick_cnt_r == TICK_CYCLES - 1)
            tick_cnt_r <= 32'h0;
         else
            tick_cnt_r <= tick_cnt_r + 32'h1;
      end
   end

   // ================================================================
   // Ramp generators, one step per tick
   always @(posedge clk) begin
      if (rst) begin
         vel_dem_r <= 32'sh0;
         acc_now_r <= 32'sh0;
         trq_dem_r <= 32'sh0;
      end else if (ce) begin
         // Power stage off: demands drop at once, nothing to ramp
         if (!pv_on) begin
            vel_dem_r <= 32'sh0;
            acc_now_r <= 32'sh0;
         end else if (tick_r) begin
            // ramp toward target within speed and slope limits
            vel_dem_r <= f_step(vel_dem_r, vel_ref, vel_step);
            acc_now_r <= (vel_dem_r == vel_ref) ? 32'sh0 : vel_step;
         end
         if (!pt_on)
            trq_dem_r <= 32'sh0;
         else if (tick_r)
            // rate limited by slope per second
            trq_dem_r <= f_clamp(f_step(trq_dem_r, trq_ref, f_per_tick(trq_slope_r)),
                                 trq_cap);
      end
   end

   // ================================================================
   // Window timer and status flags
   always @(posedge clk) begin
      if (rst) begin
         win_cnt_r    <= 32'h0;
         reached_r    <= 1'b0;
         limit_r      <= 1'b0;
         halt_d_r     <= 1'b0;
         cond_sel_d_r <= 2'h0;
      end else if (ce) begin
         halt_d_r     <= halt;
         cond_sel_d_r <= cond_sel;
         // Restart timing whenever the judged quantity changes
         if (!in_win || halt != halt_d_r || cond_sel != cond_sel_d_r) begin
            win_cnt_r <= 32'h0;
            reached_r <= 1'b0;
         end else if (win_cnt_r >= win_time) begin
            reached_r <= pv_on | pt_on;
         end else if (tick_r) begin
            win_cnt_r <= win_cnt_r + 32'h1;
         end
         if (pt_on)
            limit_r <= f_abs($signed(tgt_trq_r)) > $signed(max_trq_r);
         else
            limit_r <= pv_on & vel_clip;
      end
   end

   // ================================================================
   // Outputs to the controller, all registered
   always @(posedge clk) begin
      if (rst) begin
         vel_setpoint  <= 32'h0;
         trq_setpoint  <= 32'h0;
         speed_limit   <= 32'h0;
         true_torque   <= 1'b0;
         field_weak_en <= 1'b0;
         mode_active   <= 2'h0;
      end else if (ce) begin
         // demand is also the speed setpoint
         vel_setpoint  <= vel_dem_r;
         // torque demand goes to the controller
         trq_setpoint  <= trq_dem_r;
         // submode bit 5 selects true torque control
         true_torque   <= sub_r[`PVT_SUB_TRQ];
         field_weak_en <= pt_on & ~sub_r[`PVT_SUB_TRQ];
         speed_limit   <= sub_r[`PVT_SUB_TRQ] ? `PVT_RST_MAXVEL : max_vel_r;
         mode_active   <= {pt_on, pv_on};
      end
   end

   // ================================================================
   // Register reads, data one cycle after the strobe
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 32'h0;
      end else if (ce) begin
         reg_rdata <= 32'h0;
         if (reg_rd) begin
            case (reg_addr)
               `PVT_A_MODE:      reg_rdata <= {24'h0, mode_r};
               `PVT_A_CTRL:      reg_rdata <= ctrl_r;
               // bit 10 read together with halt
               `PVT_A_STAT:      reg_rdata <= ({31'h0, reached_r} << `PVT_STAT_TREACH) |
                                              ({31'h0, limit_r} << `PVT_STAT_LIMIT);
               `PVT_A_TGT_VEL:   reg_rdata <= tgt_vel_r;
               `PVT_A_VEL_DEM:   reg_rdata <= vel_dem_r;
               `PVT_A_VEL_ACT:   reg_rdata <= vel_actual;
               `PVT_A_VEL_WIN:   reg_rdata <= vel_win_r;
               `PVT_A_VEL_WTIME: reg_rdata <= vel_wtime_r;
               `PVT_A_POLARITY:  reg_rdata <= pol_r;
               `PVT_A_ACC:       reg_rdata <= acc_r;
               `PVT_A_DEC:       reg_rdata <= dec_r;
               `PVT_A_QS_DEC:    reg_rdata <= qs_dec_r;
               `PVT_A_PROF_TYPE: reg_rdata <= prof_r;
               `PVT_A_JERK:      reg_rdata <= jerk_r;
               `PVT_A_MAX_VEL:   reg_rdata <= max_vel_r;
               // torque values are per-mille of rated
               `PVT_A_TGT_TRQ:   reg_rdata <= tgt_trq_r;
               `PVT_A_MAX_TRQ:   reg_rdata <= max_trq_r;
               `PVT_A_TRQ_DEM:   reg_rdata <= trq_dem_r;
               `PVT_A_TRQ_SLOPE: reg_rdata <= trq_slope_r;
               `PVT_A_TRQ_ACT:   reg_rdata <= trq_actual;
               `PVT_A_TRQ_WIN:   reg_rdata <= trq_win_r;
               `PVT_A_TRQ_WTIME: reg_rdata <= trq_wtime_r;
               `PVT_A_PEAK_TRQ:  reg_rdata <= peak_trq_r;
               `PVT_A_PEAK_EN:   reg_rdata <= {31'h0, peak_en_r};
               `PVT_A_SUBMODE:   reg_rdata <= sub_r;
               default:          reg_rdata <= 32'h0;
            endcase
         end
      end
   end

endmodule
`default_nettype wire
